// ==== hw/tmwd_pkg.sv ====
// constants for the timer and watchdog group: register map, fields, timing
// assumes a 32-bit classic wishbone slave port with word-aligned registers
// Contract
// - timer prescaler divides by 1 to 65536
// - 54-bit timer counter counts up or down
// - timer reloads programmed value in either direction
// - live timer count readable while running
// - halted timer keeps value, resumes from it
// - two 52-bit counters, three attachable comparators
// - system counters advance at fixed 16 MHz
// - one interrupt per comparator on match
// - target mode fires once, period mode repeats
// - target 52 bits wide, period 26 bits
// - software value loads into a system counter
// - system counters optionally stop on stall/debug
// - three watchdogs: two main, one rtc
// - flash boot arms rtc and first-group watchdog
// - four staged timeouts, 32-bit expiry counter
// - each watchdog stage enabled separately
// - main watchdog: irq, cpu or core reset
// - rtc watchdog adds full system reset action
// - watchdog settings locked unless unlocked first
// - unfinished flash boot reboots main system
package tmwd_pkg;
   localparam int ADR_W = 8;
   localparam int IDX_W = 6;
   // general-purpose timers, eight words each
   localparam int GT_N = 2;
   localparam int GT_W = 54;
   localparam int GT_BASE = 0;
   localparam int GT_STRIDE = 8;
   localparam int GT_CFG = 0;
   localparam int GT_LDLO = 1;
   localparam int GT_LDHI = 2;
   localparam int GT_ALLO = 3;
   localparam int GT_ALHI = 4;
   localparam int GT_CNTLO = 5;
   localparam int GT_CNTHI = 6;
   localparam int GT_CTL = 7;
   localparam int GT_EN_BIT = 0;
   localparam int GT_UP_BIT = 1;
   localparam int GT_AR_BIT = 2;
   localparam int GT_AE_BIT = 3;
   localparam int GT_DIV_LSB = 16;
   localparam int GT_DIV_W = 16;
   localparam int GT_CTL_LOAD = 0;
   localparam int GT_CTL_CLR = 1;
   // system timer
   localparam int ST_N = 2;
   localparam int CMP_N = 3;
   localparam int ST_W = 52;
   localparam int PER_W = 26;
   localparam int ST_CFG = 16;
   localparam int ST_LD_BASE = 17;
   localparam int ST_CTL = 21;
   localparam int ST_CNT_BASE = 22;
   localparam int ST_EN_LSB = 0;
   localparam int ST_STALL_LSB = 2;
   localparam int ST_CLR_LSB = 8;
   localparam int CMP_BASE = 26;
   localparam int CMP_STRIDE = 4;
   localparam int CMP_CFG = 0;
   localparam int CMP_TLO = 1;
   localparam int CMP_THI = 2;
   localparam int CMP_PER = 3;
   localparam int CMP_EN_BIT = 0;
   localparam int CMP_MODE_BIT = 1;
   localparam int CMP_SEL_BIT = 2;
   localparam int SYS_HZ = 125000000;
   localparam int ST_HZ = 16000000;
   localparam int ST_INC = ST_HZ / 1000000;
   localparam int ST_MOD = SYS_HZ / 1000000;
   // watchdogs
   localparam int WD_N = 3;
   localparam int WD_FIRST = 0;
   localparam int WD_RTC = 2;
   localparam int WD_W = 32;
   localparam int WD_KEY = 39;
   localparam int WD_BASE = 40;
   localparam int WD_STRIDE = 8;
   localparam int WD_CFG = 0;
   localparam int WD_TMO = 1;
   localparam int WD_FEED = 5;
   localparam int WD_STAT = 6;
   localparam int WD_CNT = 7;
   localparam int WD_EN_BIT = 0;
   localparam int WD_SEN_LSB = 1;
   localparam int WD_ACT_LSB = 5;
   localparam int WD_ACT_W = 3;
   localparam int WD_STG_LSB = 4;
   localparam logic [31:0] WD_UNLOCK_KEY = 32'h1f2e_3d4c;
   localparam logic [2:0] ACT_NONE = 3'h0;
   localparam logic [2:0] ACT_IRQ = 3'h1;
   localparam logic [2:0] ACT_CPU = 3'h2;
   localparam logic [2:0] ACT_CORE = 3'h3;
   localparam logic [2:0] ACT_SYS = 3'h4;
endpackage

// ==== hw/tmwd_top.sv ====
// timer group: two general timers, a system timer, three watchdogs
// assumes one 125 MHz clock, sync reset, classic wishbone master
`timescale 1ns/1ns
module tmwd_top #(
   parameter logic [31:0] BOOT_TMO = 32'd125000000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [tmwd_pkg::ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic cpu_stall_i,
   input wire logic halted_debug_state_i,
   input wire logic flash_boot_i,
   output logic [tmwd_pkg::GT_N-1:0] gt_irq_o,
   output logic [tmwd_pkg::CMP_N-1:0] st_irq_o,
   output logic [tmwd_pkg::WD_N-1:0] wd_irq_o,
   output logic cpu_rst_o,
   output logic core_rst_o,
   output logic sys_rst_o
);
   import tmwd_pkg::*;

   function automatic logic hit(input logic en, input logic [IDX_W-1:0] i, input int a);
      return en && (i == IDX_W'(a));
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = n[8*b +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus slave
   logic ack_q;
   logic [31:0] dat_q;
   logic [31:0] rd;
   logic [31:0] wdat;
   logic [IDX_W-1:0] idx;
   logic wr;

   assign idx = adr_i[ADR_W-1:2];
   assign wr = cyc_i && stb_i && we_i && ack_q;
   assign wdat = merge(rd, dat_i, sel_i);
   assign ack_o = ack_q;
   assign dat_o = dat_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= cyc_i && stb_i && !ack_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (cyc_i && stb_i && !ack_q) begin
         dat_q <= rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and boot strap capture
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [1:0] boot_cnt_q;
   logic boot_arm;
   logic held;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end else begin
         sync1_q <= {flash_boot_i, halted_debug_state_i, cpu_stall_i};
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_cnt_q <= 2'h0;
      end else if (boot_cnt_q != 2'h3) begin
         boot_cnt_q <= boot_cnt_q + 2'h1;
      end
   end

   assign boot_arm = (boot_cnt_q == 2'h2) && sync2_q[2];
   assign held = sync2_q[0] || sync2_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // general-purpose timers
   logic [31:0] gt_rd [GT_N];

   for (genvar g = 0; g < GT_N; g++) begin : g_gt
      localparam int B = GT_BASE + g * GT_STRIDE;
      logic [31:0] cfg_q;
      logic [GT_W-1:0] ld_q;
      logic [GT_W-1:0] al_q;
      logic [GT_W-1:0] cnt_q;
      logic [GT_DIV_W-1:0] pre_q;
      logic irq_q;
      logic tick;
      logic alarm;

      // >= so a divider lowered below the running prescale ticks at once
      assign tick = cfg_q[GT_EN_BIT] && (pre_q >= cfg_q[GT_DIV_LSB +: GT_DIV_W]);
      assign alarm = tick && cfg_q[GT_AE_BIT] && (cnt_q == al_q);

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cfg_q <= 32'h0000_0000;
            ld_q <= '0;
            al_q <= '0;
         end else begin
            if (hit(wr, idx, B + GT_CFG)) cfg_q <= wdat;
            if (hit(wr, idx, B + GT_LDLO)) ld_q[31:0] <= wdat;
            if (hit(wr, idx, B + GT_LDHI)) ld_q[GT_W-1:32] <= wdat[GT_W-33:0];
            if (hit(wr, idx, B + GT_ALLO)) al_q[31:0] <= wdat;
            if (hit(wr, idx, B + GT_ALHI)) al_q[GT_W-1:32] <= wdat[GT_W-33:0];
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pre_q <= '0;
         end else if (tick) begin
            pre_q <= '0;
         end else if (cfg_q[GT_EN_BIT]) begin
            pre_q <= pre_q + 1'b1;
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cnt_q <= '0;
         end else if (hit(wr, idx, B + GT_CTL) && wdat[GT_CTL_LOAD]) begin
            cnt_q <= ld_q;
         end else if (alarm && cfg_q[GT_AR_BIT]) begin
            cnt_q <= ld_q;
         end else if (tick) begin
            cnt_q <= cfg_q[GT_UP_BIT] ? cnt_q + 1'b1 : cnt_q - 1'b1;
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            irq_q <= 1'b0;
         end else if (alarm) begin
            irq_q <= 1'b1;
         end else if (hit(wr, idx, B + GT_CTL) && wdat[GT_CTL_CLR]) begin
            irq_q <= 1'b0;
         end
      end

      assign gt_irq_o[g] = irq_q;

      always_comb begin
         unique case (idx[2:0])
            3'(GT_CFG): gt_rd[g] = cfg_q;
            3'(GT_LDLO): gt_rd[g] = ld_q[31:0];
            3'(GT_LDHI): gt_rd[g] = {10'h000, ld_q[GT_W-1:32]};
            3'(GT_ALLO): gt_rd[g] = al_q[31:0];
            3'(GT_ALHI): gt_rd[g] = {10'h000, al_q[GT_W-1:32]};
            3'(GT_CNTLO): gt_rd[g] = cnt_q[31:0];
            3'(GT_CNTHI): gt_rd[g] = {10'h000, cnt_q[GT_W-1:32]};
            3'(GT_CTL): gt_rd[g] = {31'h0000_0000, irq_q};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // system timer: 16 MHz tick by fractional accumulation
   logic [6:0] acc_q;
   logic st_tick;
   logic [31:0] st_cfg_q;
   logic [ST_W-1:0] st_cnt [ST_N];
   logic [31:0] cmp_rd [CMP_N];

   assign st_tick = acc_q >= 7'(ST_MOD - ST_INC);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= 7'h00;
      end else if (st_tick) begin
         acc_q <= acc_q - 7'(ST_MOD - ST_INC);
      end else begin
         acc_q <= acc_q + 7'(ST_INC);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_cfg_q <= 32'h0000_0000;
      end else if (hit(wr, idx, ST_CFG)) begin
         st_cfg_q <= wdat;
      end
   end

   for (genvar c = 0; c < ST_N; c++) begin : g_stc
      logic [ST_W-1:0] ld_q;
      logic [ST_W-1:0] cnt_q;
      logic run;

      assign run = st_cfg_q[ST_EN_LSB + c] && !(st_cfg_q[ST_STALL_LSB + c] && held);
      assign st_cnt[c] = cnt_q;

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ld_q <= '0;
         end else begin
            if (hit(wr, idx, ST_LD_BASE + 2 * c)) ld_q[31:0] <= wdat;
            if (hit(wr, idx, ST_LD_BASE + 2 * c + 1)) ld_q[ST_W-1:32] <= wdat[ST_W-33:0];
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cnt_q <= '0;
         end else if (hit(wr, idx, ST_CTL) && wdat[c]) begin
            cnt_q <= ld_q;
         end else if (st_tick && run) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   for (genvar k = 0; k < CMP_N; k++) begin : g_cmp
      localparam int B = CMP_BASE + k * CMP_STRIDE;
      logic [2:0] cfg_q;
      logic [ST_W-1:0] tgt_q;
      logic [PER_W-1:0] per_q;
      logic prev_q;
      logic irq_q;
      logic match;
      logic ev;

      assign match = cfg_q[CMP_EN_BIT] && (st_cnt[cfg_q[CMP_SEL_BIT]] == tgt_q);
      assign ev = match && !prev_q;

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cfg_q <= 3'h0;
            per_q <= '0;
            prev_q <= 1'b0;
         end else begin
            prev_q <= match;
            if (hit(wr, idx, B + CMP_CFG)) cfg_q <= wdat[2:0];
            if (hit(wr, idx, B + CMP_PER)) per_q <= wdat[PER_W-1:0];
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            tgt_q <= '0;
         end else if (hit(wr, idx, B + CMP_TLO)) begin
            tgt_q[31:0] <= wdat;
         end else if (hit(wr, idx, B + CMP_THI)) begin
            tgt_q[ST_W-1:32] <= wdat[ST_W-33:0];
         end else if (ev && cfg_q[CMP_MODE_BIT]) begin
            tgt_q <= tgt_q + ST_W'(per_q);
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            irq_q <= 1'b0;
         end else if (ev) begin
            irq_q <= 1'b1;
         end else if (hit(wr, idx, ST_CTL) && wdat[ST_CLR_LSB + k]) begin
            irq_q <= 1'b0;
         end
      end

      assign st_irq_o[k] = irq_q;

      always_comb begin
         unique case (idx[1:0])
            2'(CMP_CFG): cmp_rd[k] = {29'h0000_0000, cfg_q};
            2'(CMP_TLO): cmp_rd[k] = tgt_q[31:0];
            2'(CMP_THI): cmp_rd[k] = {12'h000, tgt_q[ST_W-1:32]};
            2'(CMP_PER): cmp_rd[k] = {6'h00, per_q};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdogs: two main group watchdogs and one rtc domain watchdog
   logic unl_q;
   logic [31:0] wd_rd [WD_N];
   logic [WD_N-1:0] wd_cpu;
   logic [WD_N-1:0] wd_core;
   logic [WD_N-1:0] wd_sys;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unl_q <= 1'b0;
      end else if (hit(wr, idx, WD_KEY)) begin
         unl_q <= wdat == WD_UNLOCK_KEY;
      end
   end

   for (genvar w = 0; w < WD_N; w++) begin : g_wd
      localparam int B = WD_BASE + w * WD_STRIDE;
      localparam logic [2:0] BOOT_ACT = (w == WD_RTC) ? ACT_SYS : ACT_CORE;
      logic [31:0] cfg_q;
      logic [WD_W-1:0] tmo_q [4];
      logic [WD_W-1:0] cnt_q;
      logic [1:0] stg_q;
      logic irq_q;
      logic sen;
      logic adv;
      logic fire;
      logic [2:0] act;
      logic restart;

      assign sen = cfg_q[WD_SEN_LSB + stg_q];
      assign adv = cfg_q[WD_EN_BIT] && (!sen || cnt_q >= tmo_q[stg_q]);
      assign fire = adv && sen;
      assign act = cfg_q[WD_ACT_LSB + WD_ACT_W * stg_q +: WD_ACT_W];
      assign restart = unl_q && (hit(wr, idx, B + WD_FEED) || hit(wr, idx, B + WD_CFG));
      assign wd_cpu[w] = fire && (act == ACT_CPU);
      assign wd_core[w] = fire && (act == ACT_CORE);
      assign wd_sys[w] = fire && (act == ACT_SYS) && (w == WD_RTC);

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cfg_q <= 32'h0000_0000;
            for (int s = 0; s < 4; s++) tmo_q[s] <= '0;
         end else if (boot_arm && (w == WD_FIRST || w == WD_RTC)) begin
            cfg_q <= 32'h0000_0000;
            cfg_q[WD_EN_BIT] <= 1'b1;
            cfg_q[WD_SEN_LSB] <= 1'b1;
            cfg_q[WD_ACT_LSB +: WD_ACT_W] <= BOOT_ACT;
            tmo_q[0] <= BOOT_TMO;
         end else if (unl_q) begin
            if (hit(wr, idx, B + WD_CFG)) cfg_q <= wdat;
            for (int s = 0; s < 4; s++) begin
               if (hit(wr, idx, B + WD_TMO + s)) tmo_q[s] <= wdat;
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i || restart || boot_arm) begin
            cnt_q <= '0;
            stg_q <= 2'h0;
         end else if (adv) begin
            cnt_q <= '0;
            stg_q <= stg_q + 2'h1;
         end else if (cfg_q[WD_EN_BIT]) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            irq_q <= 1'b0;
         end else if (fire && act == ACT_IRQ) begin
            irq_q <= 1'b1;
         end else if (hit(wr, idx, B + WD_STAT) && wdat[0]) begin
            irq_q <= 1'b0;
         end
      end

      assign wd_irq_o[w] = irq_q;

      always_comb begin
         wd_rd[w] = 32'h0000_0000;
         if (idx[2:0] == 3'(WD_CFG)) begin
            wd_rd[w] = cfg_q;
         end else if (idx[2:0] == 3'(WD_STAT)) begin
            wd_rd[w] = {26'h000_0000, stg_q, 3'h0, irq_q};
         end else if (idx[2:0] == 3'(WD_CNT)) begin
            wd_rd[w] = cnt_q;
         end else if (idx[2:0] != 3'(WD_FEED)) begin
            wd_rd[w] = tmo_q[2'(idx[2:0] - 3'(WD_TMO))];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_rst_o <= 1'b0;
         core_rst_o <= 1'b0;
         sys_rst_o <= 1'b0;
      end else begin
         cpu_rst_o <= |wd_cpu;
         core_rst_o <= |wd_core;
         sys_rst_o <= |wd_sys;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped words read zero
   logic st_sel;

   assign st_sel = 1'((idx - IDX_W'(ST_CNT_BASE)) >> 1);

   always_comb begin
      rd = 32'h0000_0000;
      if (idx < IDX_W'(GT_BASE + GT_N * GT_STRIDE)) begin
         rd = gt_rd[idx[3]];
      end else if (idx == IDX_W'(ST_CFG)) begin
         rd = st_cfg_q;
      end else if (idx == IDX_W'(ST_CTL)) begin
         rd = {21'h00_0000, st_irq_o, 8'h00};
      end else if (idx >= IDX_W'(ST_CNT_BASE) && idx < IDX_W'(CMP_BASE)) begin
         rd = idx[0] ? {12'h000, st_cnt[st_sel][ST_W-1:32]} : st_cnt[st_sel][31:0];
      end else if (idx >= IDX_W'(CMP_BASE) && idx < IDX_W'(CMP_BASE + CMP_N * CMP_STRIDE)) begin
         rd = cmp_rd[2'((idx - IDX_W'(CMP_BASE)) >> 2)];
      end else if (idx == IDX_W'(WD_KEY)) begin
         rd = {31'h0000_0000, unl_q};
      end else if (idx >= IDX_W'(WD_BASE)) begin
         rd = wd_rd[2'((idx - IDX_W'(WD_BASE)) >> 3)];
      end
   end
endmodule

// ==== bench/tmwd_top_assertions.sv ====
// checker for the timer and watchdog group: bus handshake, sticky irqs, reset pulses
// assumes binding onto tmwd_top, one clock, synchronous active-high reset
`timescale 1ns/1ns
module tmwd_top_assertions
   import tmwd_pkg::*;
#(
   parameter logic [31:0] BOOT_TMO = 32'd125000000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [tmwd_pkg::ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic cpu_stall_i,
   input wire logic halted_debug_state_i,
   input wire logic flash_boot_i,
   input wire logic [tmwd_pkg::GT_N-1:0] gt_irq_o,
   input wire logic [tmwd_pkg::CMP_N-1:0] st_irq_o,
   input wire logic [tmwd_pkg::WD_N-1:0] wd_irq_o,
   input wire logic cpu_rst_o,
   input wire logic core_rst_o,
   input wire logic sys_rst_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   property p_ack_one; ack_o |=> !ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack held over one cycle");
   property p_ack_wait; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_wait: assert property (p_ack_wait) else $error("ack not one cycle after request");
   property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_gt_hold;
      $fell(gt_irq_o[0]) |-> $past(ack_o && we_i && sel_i[0] && dat_i[GT_CTL_CLR]
         && adr_i[7:2] == IDX_W'(GT_BASE + GT_CTL));
   endproperty
   a_gt_hold: assert property (p_gt_hold) else $error("timer irq dropped uncleared");
   property p_st_hold;
      $fell(st_irq_o[0]) |-> $past(ack_o && we_i && sel_i[1] && dat_i[ST_CLR_LSB]
         && adr_i[7:2] == IDX_W'(ST_CTL));
   endproperty
   a_st_hold: assert property (p_st_hold) else $error("comparator irq dropped uncleared");
   property p_wd_hold;
      $fell(wd_irq_o[0]) |-> $past(ack_o && we_i && sel_i[0] && dat_i[0]
         && adr_i[7:2] == IDX_W'(WD_BASE + WD_STAT));
   endproperty
   a_wd_hold: assert property (p_wd_hold) else $error("watchdog irq dropped uncleared");
   property p_cpu_pulse; cpu_rst_o |=> !cpu_rst_o; endproperty
   a_cpu_pulse: assert property (p_cpu_pulse) else $error("cpu reset pulse too long");
   property p_core_pulse; core_rst_o |=> !core_rst_o; endproperty
   a_core_pulse: assert property (p_core_pulse) else $error("core reset pulse too long");
   property p_sys_pulse; sys_rst_o |=> !sys_rst_o; endproperty
   a_sys_pulse: assert property (p_sys_pulse) else $error("system reset pulse too long");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind tmwd_top tmwd_top_assertions #(.BOOT_TMO(BOOT_TMO)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .cpu_stall_i(cpu_stall_i),
   .halted_debug_state_i(halted_debug_state_i), .flash_boot_i(flash_boot_i),
   .gt_irq_o(gt_irq_o), .st_irq_o(st_irq_o), .wd_irq_o(wd_irq_o), .cpu_rst_o(cpu_rst_o),
   .core_rst_o(core_rst_o), .sys_rst_o(sys_rst_o));

// ==== bench/tmwd_top_test.sv ====
// self-checking bench for the timer and watchdog group
// assumes tmwd_top with a short boot timeout and a 125 MHz clock
`timescale 1ns/1ns
module tmwd_top_test;
   import tmwd_pkg::*;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cpu_rst_o, core_rst_o, sys_rst_o;
   logic cpu_stall_i, halted_debug_state_i, flash_boot_i;
   logic [ADR_W-1:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o;
   logic [GT_N-1:0] gt_irq_o;
   logic [CMP_N-1:0] st_irq_o;
   logic [WD_N-1:0] wd_irq_o;
   logic [7:0] irqs;
   int n_errors = 0, n_compared = 0, t_ack, n_cpu = 0, n_core = 0, n_sys = 0;
   assign irqs = {wd_irq_o, st_irq_o, gt_irq_o};
   tmwd_top #(.BOOT_TMO(32'd50)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .cpu_stall_i(cpu_stall_i), .halted_debug_state_i(halted_debug_state_i),
      .flash_boot_i(flash_boot_i), .gt_irq_o(gt_irq_o), .st_irq_o(st_irq_o),
      .wd_irq_o(wd_irq_o), .cpu_rst_o(cpu_rst_o), .core_rst_o(core_rst_o), .sys_rst_o(sys_rst_o));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (cpu_rst_o === 1'b1) n_cpu++;
      if (core_rst_o === 1'b1) n_core++;
      if (sys_rst_o === 1'b1) n_sys++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task check(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task ok(input logic c);
      check({63'h0, c}, 64'h1);
   endtask
   task bus(input logic w, input int idx, input logic [31:0] d, output logic [31:0] q);
      int n;
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= ADR_W'(idx * 4);
      dat_i <= d; sel_i <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         n_errors++;
         conclude();
      end
      q = dat_o;
      t_ack = int'($time / 8);
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task wr(input int idx, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask
   task rd(input int idx, output logic [31:0] q);
      bus(1'b0, idx, 32'h0, q);
   endtask
   task wait_bit(input int b, input int lim, output int n);
      n = 0;
      while (irqs[b] !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if (irqs[b] !== 1'b1) begin
         n_errors++;
         conclude();
      end
   endtask
   task do_reset;
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_gtimer;
      logic [31:0] a, b, c;
      int s;
      wr(GT_LDLO, 32'd100); wr(GT_CTL, 32'h1); wr(GT_CFG, 32'h0003_0003);
      rd(GT_CNTLO, a); s = t_ack; repeat (40) @(posedge clk_i); rd(GT_CNTLO, b);
      s = t_ack - s;
      ok((b - a) * 4 <= s + 4 && (b - a) * 4 + 4 >= s);
      wr(GT_CFG, 32'h0003_0002); rd(GT_CNTLO, a); repeat (20) @(posedge clk_i); rd(GT_CNTLO, b);
      check(b, a);
      wr(GT_CFG, 32'h0003_0003); repeat (20) @(posedge clk_i); rd(GT_CNTLO, c);
      ok(c > b && c < b + 20);
      wr(GT_CFG, 32'hffff_0003); wr(GT_CTL, 32'h1);
      rd(GT_CNTLO, a); repeat (100) @(posedge clk_i); rd(GT_CNTLO, b);
      ok(b - a <= 1);
      for (int g = 0; g < GT_N; g++) begin
         wr(8 * g + GT_LDLO, g ? 0 : 40); wr(8 * g + GT_ALLO, g ? 25 : 10);
         wr(8 * g + GT_CTL, 32'h1); wr(8 * g + GT_CFG, g ? 32'hf : 32'hd);
         wait_bit(g, 200, s);
         rd(8 * g + GT_CNTLO, a);
         ok(g ? a < 25 : (a > 10 && a <= 40));
         wr(8 * g + GT_CFG, 32'h0); ok(gt_irq_o[g] === 1'b1);
         wr(8 * g + GT_CTL, 32'h2); ok(gt_irq_o[g] === 1'b0);
      end
   endtask
   task t_systimer;
      logic [31:0] a, b, c, d;
      int s;
      wr(ST_CFG, 32'h3); wr(ST_CTL, 32'h3);
      rd(ST_CNT_BASE, a); s = t_ack; repeat (250) @(posedge clk_i); rd(ST_CNT_BASE, b);
      s = t_ack - s;
      ok((b - a) * 125 <= s * 16 + 125 && (b - a) * 125 + 125 >= s * 16);
      wr(ST_LD_BASE, 32'd1000); wr(ST_CTL, 32'h1); rd(ST_CNT_BASE, a);
      ok(a >= 1000 && a < 1010);
      wr(ST_CFG, 32'h7);
      for (int i = 0; i < 2; i++) begin
         if (i == 0) cpu_stall_i <= 1'b1;
         else halted_debug_state_i <= 1'b1;
         repeat (5) @(posedge clk_i);
         rd(ST_CNT_BASE, a); rd(ST_CNT_BASE + 2, c); repeat (100) @(posedge clk_i);
         rd(ST_CNT_BASE, b); rd(ST_CNT_BASE + 2, d);
         check(b, a);
         ok(d > c);
         cpu_stall_i <= 1'b0; halted_debug_state_i <= 1'b0; repeat (20) @(posedge clk_i);
         rd(ST_CNT_BASE, c); ok(c > b);
      end
      wr(ST_CFG, 32'h3); wr(ST_LD_BASE, 32'h0); wr(ST_CTL, 32'h3);
      for (int k = 0; k < CMP_N; k++) begin
         wr(CMP_BASE + 4 * k + CMP_TLO, 32'd200); wr(CMP_BASE + 4 * k + CMP_PER, 32'd100);
         wr(CMP_BASE + 4 * k, k == 0 ? 32'h1 : (k == 1 ? 32'h5 : 32'h7));
      end
      for (int k = 0; k < CMP_N; k++) wait_bit(2 + k, 3000, s);
      wr(ST_CTL, 32'h700); ok(st_irq_o === 3'b000);
      wait_bit(4, 1200, s);
      ok(st_irq_o[1:0] === 2'b00);
      wr(CMP_BASE + 8, 32'h0);
   endtask
   task t_watchdog;
      logic [31:0] a;
      logic [2:0] acts [4];
      logic [2:0] exps [4];
      int n, c0, c1, c2, w;
      acts = '{ACT_CPU, ACT_CORE, ACT_SYS, ACT_SYS};
      exps = '{3'b100, 3'b010, 3'b000, 3'b001};
      wr(WD_BASE, 32'h3); rd(WD_BASE, a); check(a, 0);
      wr(WD_KEY, WD_UNLOCK_KEY); rd(WD_KEY, a); check(a, 1);
      for (int s = 0; s < 4; s++) wr(WD_BASE + 8 + WD_TMO + s, 32'd10);
      wr(WD_BASE + 8, 32'h0000_401f); wait_bit(6, 100, n);
      ok(n >= 28);
      wr(WD_BASE + 8 + WD_TMO, 32'd40); wr(WD_BASE + 8, 32'h0000_0105);
      wr(WD_BASE + 8 + WD_STAT, 32'h1); wait_bit(6, 100, n);
      ok(n <= 12);
      wr(WD_BASE + 8, 32'h0); wr(WD_BASE + 8 + WD_STAT, 32'h1);
      ok(wd_irq_o[1] === 1'b0);
      for (int i = 0; i < 4; i++) begin
         w = (i == 3) ? 2 : 0;
         c0 = n_cpu; c1 = n_core; c2 = n_sys;
         wr(WD_BASE + 8 * w + WD_TMO, 32'd10);
         wr(WD_BASE + 8 * w, 32'h3 | (32'(acts[i]) << WD_ACT_LSB));
         repeat (30) @(posedge clk_i);
         wr(WD_BASE + 8 * w, 32'h0);
         check({n_cpu > c0, n_core > c1, n_sys > c2}, exps[i]);
      end
      wr(WD_BASE + WD_TMO, 32'd40); wr(WD_BASE, 32'h23);
      for (int i = 0; i < 6; i++) begin
         repeat (20) @(posedge clk_i);
         wr(WD_BASE + WD_FEED, 32'h0);
      end
      ok(wd_irq_o[0] === 1'b0);
      wr(WD_KEY, 32'h0); wr(WD_BASE + WD_FEED, 32'h0); wait_bit(5, 80, n);
      wr(WD_KEY, WD_UNLOCK_KEY); wr(WD_BASE, 32'h0); wr(WD_BASE + WD_STAT, 32'h1);
      ok(wd_irq_o[0] === 1'b0);
      wr(WD_KEY, 32'h0);
   endtask
   task t_boot;
      int c0, c1, c2;
      flash_boot_i <= 1'b1;
      do_reset();
      c0 = n_cpu; c1 = n_core; c2 = n_sys;
      repeat (80) @(posedge clk_i);
      check({n_cpu > c0, n_core > c1, n_sys > c2}, 3'b011);
      wr(WD_KEY, WD_UNLOCK_KEY); wr(WD_BASE, 32'h0); wr(WD_BASE + 16, 32'h0); wr(WD_KEY, 32'h0);
      flash_boot_i <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = '0;
      sel_i = 4'h0; dat_i = 32'h0; cpu_stall_i = 1'b0; halted_debug_state_i = 1'b0;
      flash_boot_i = 1'b0;
      do_reset();
      t_gtimer();
      t_systimer();
      t_watchdog();
      t_boot();
      conclude();
   end
endmodule
